// File: common/rsf_pkg.sv
// Purpose: Shared constants for the run source and reference select block.
// Assumes: References are in units of 0.01 % of the maximum output frequency.
// Notes: Converter codes are 12-bit, full scale at 10 V or 20 mA.
`default_nettype none
package rsf_pkg;
  // ==========================================
  // Parameter register addresses
  // ==========================================
  localparam logic [15:0] ADDR_RUN_SRC = 16'h0103;
  localparam logic [15:0] ADDR_REM_REF = 16'h0104;
  localparam logic [15:0] ADDR_HALT_KEY = 16'h0107;
  localparam logic [15:0] ADDR_LOC_REF = 16'h0108;
  localparam logic [15:0] ADDR_UPPER = 16'h0121;
  localparam logic [15:0] ADDR_LOWER = 16'h0122;
  localparam logic [15:0] ADDR_PRESET_BASE = 16'h0130;
  localparam logic [15:0] ADDR_PULSE_SCALE = 16'h0195;
  localparam int NUM_PRESETS = 16;
  // ==========================================
  // Ranges and reset values
  // ==========================================
  localparam logic [15:0] RUN_SRC_MAX = 16'h0003;
  localparam logic [15:0] REM_REF_MAX = 16'h0009;
  localparam logic [15:0] FLAG_MAX = 16'h0001;
  localparam logic [15:0] LIMIT_MAX = 16'h006E;
  localparam logic [15:0] UPPER_RESET = 16'h0064;
  localparam logic [15:0] LOWER_RESET = 16'h0000;
  localparam logic [15:0] PULSE_SCALE_RESET = 16'h0064;
  // ==========================================
  // Scaling constants
  // ==========================================
  localparam logic [15:0] FULL_REF = 16'h2710;
  localparam logic [15:0] PCT_UNIT = 16'h0064;
  localparam logic [11:0] ADC_ZERO = 12'h0000;
  localparam logic [11:0] ADC_4MA = 12'h0333;
  localparam logic [11:0] ADC_SPAN_FULL = 12'h0FFF;
  localparam logic [11:0] ADC_SPAN_4MA = 12'h0CCC;
  localparam logic [15:0] REF_SAT = 16'hFFFF;
  // ==========================================
  // Source encodings
  // ==========================================
  localparam logic [1:0] RUN_PANEL = 2'h0;
  localparam logic [1:0] RUN_TERM = 2'h1;
  localparam logic [1:0] RUN_MODBUS = 2'h2;
  localparam logic [1:0] RUN_FIELDBUS = 2'h3;
  localparam logic [3:0] REF_KNOB = 4'h0;
  localparam logic [3:0] REF_PRESET = 4'h1;
  localparam logic [3:0] REF_VOLT = 4'h2;
  localparam logic [3:0] REF_CUR_4 = 4'h3;
  localparam logic [3:0] REF_CUR_0 = 4'h4;
  localparam logic [3:0] REF_PULSE = 4'h5;
  localparam logic [3:0] REF_MODBUS = 4'h6;
  localparam logic [3:0] REF_AUX_V = 4'h7;
  localparam logic [3:0] REF_AUX_I = 4'h8;
  localparam logic [3:0] REF_FIELDBUS = 4'h9;
  // Operating mode of the drive.
  typedef enum logic {RSF_MODE_REMOTE, RSF_MODE_LOCAL} rsf_mode_t;
endpackage : rsf_pkg
`default_nettype wire

// File: rtl/rsf_sync.sv
// Purpose: Two-stage synchroniser for a bundle of pin levels.
// Assumes: Each bit is an independent level; no bus coherency is needed.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/1ps
`default_nettype none
module rsf_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);
  // ==========================================
  // Synchroniser stages
  // ==========================================
  logic [WIDTH-1:0] meta; // First stage, may go metastable.

  // Both stages clear to zero so no key looks pressed after reset.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= pin_in;
      sync_out <= meta;
    end
  end
endmodule : rsf_sync
`default_nettype wire

// File: rtl/rsf_select.sv
// Purpose: Run command source, frequency reference source and limit logic.
// Assumes: Parameter port and converter codes are on core_clk; keys are pins.
// Notes: Requests take one cycle; the answer appears on the next edge.
`timescale 1ns/1ps
`default_nettype none
module rsf_select
  import rsf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  // Parameter port.
  input wire logic param_req,
  input wire logic param_we,
  input wire logic [15:0] param_addr,
  input wire logic [15:0] param_wdata,
  output logic param_ack,
  output logic param_err,
  output logic [15:0] param_rdata,
  // Panel and terminal pins.
  input wire logic panel_run_key,
  input wire logic panel_stop_key,
  input wire logic panel_mode_key,
  input wire logic terminal_run,
  input wire logic [3:0] step_select,
  // Same-clock command and reference sources.
  input wire logic modbus_run,
  input wire logic fieldbus_run,
  input wire logic panel_entry_valid,
  input wire logic [15:0] panel_entry_value,
  input wire logic [11:0] panel_reference_knob,
  input wire logic [11:0] volt_in_code,
  input wire logic [11:0] current_in_code,
  input wire logic [11:0] aux_volt_code,
  input wire logic [11:0] aux_current_code,
  input wire logic [15:0] pulse_in_panel_reference_knob,
  input wire logic [15:0] modbus_reference,
  input wire logic [15:0] fieldbus_reference,
  input wire logic [15:0] minimum_output_frequency,
  // Results.
  output logic drive_run,
  output logic local_mode,
  output logic [15:0] panel_reference_knob_ref_out
);
  // ==========================================
  // Decoding helpers
  // ==========================================
  // True for the settings that are locked while running.
  function automatic logic is_cfg(input logic [15:0] a);
    is_cfg = (a == ADDR_RUN_SRC) || (a == ADDR_REM_REF) ||
             (a == ADDR_HALT_KEY) || (a == ADDR_LOC_REF) ||
             (a == ADDR_UPPER) || (a == ADDR_LOWER);
  endfunction : is_cfg

  // True when the address falls inside the preset window.
  function automatic logic is_preset(input logic [15:0] a);
    is_preset = (a >= ADDR_PRESET_BASE) &&
                (a < ADDR_PRESET_BASE + 16'(NUM_PRESETS));
  endfunction : is_preset

  // Converter code to reference; full span gives full reference.
  function automatic logic [15:0] scale_adc(input logic [11:0] code,
                                            input logic [11:0] off,
                                            input logic [11:0] span);
    logic [31:0] prod;
    prod = 32'h0000_0000;
    if (code > off) begin
      prod = (32'(code - off) * 32'(FULL_REF)) / 32'(span);
    end
    scale_adc = (prod > 32'(FULL_REF)) ? FULL_REF : prod[15:0];
  endfunction : scale_adc

  // ==========================================
  // Pin synchronisers
  // ==========================================
  logic [7:0] pins_sync; // Synchronised key and terminal levels.
  logic [2:0] keys_prev; // Previous key levels for edge detection.
  logic run_edge; // Panel run key pressed.
  logic stop_edge; // Panel stop key pressed.
  logic mode_edge; // Panel mode key pressed.
  logic term_run_s; // Terminal run level.
  logic [3:0] step_s; // Multi-step selection.

  rsf_sync #(.WIDTH(8)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in({step_select, terminal_run, panel_mode_key,
             panel_stop_key, panel_run_key}),
    .sync_out(pins_sync)
  );

  assign term_run_s = pins_sync[3];
  assign step_s = pins_sync[7:4];
  assign run_edge = pins_sync[0] & ~keys_prev[0];
  assign stop_edge = pins_sync[1] & ~keys_prev[1];
  assign mode_edge = pins_sync[2] & ~keys_prev[2];

  // Key history is taken from the second stage only.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      keys_prev <= 3'h0;
    end else begin
      keys_prev <= pins_sync[2:0];
    end
  end

  // ==========================================
  // Parameter storage
  // ==========================================
  logic [1:0] run_src; // Run command source.
  logic halt_key_sel; // 1 ignores the panel stop key against a remote level source.
  logic [3:0] rem_ref_sel; // Remote reference source.
  logic loc_ref_sel; // Local reference source.
  logic [15:0] upper_pct; // Upper limit in percent.
  logic [15:0] lower_pct; // Lower limit in percent.
  logic [15:0] pulse_input_scale; // Pulse rate equal to maximum.
  logic [15:0] preset_ref [NUM_PRESETS]; // Stored step references.
  logic wr_ok; // Current write is accepted.
  logic rng_ok; // Write data lies in the field's range.
  logic [3:0] preset_idx; // Preset slot addressed.

  assign preset_idx = 4'(param_addr - ADDR_PRESET_BASE);

  // Range checks keep out-of-range settings from ever being stored.
  always_comb begin
    rng_ok = 1'b1;
    case (param_addr)
      ADDR_RUN_SRC: rng_ok = (param_wdata <= RUN_SRC_MAX);
      ADDR_REM_REF: rng_ok = (param_wdata <= REM_REF_MAX);
      ADDR_HALT_KEY: rng_ok = (param_wdata <= FLAG_MAX);
      ADDR_LOC_REF: rng_ok = (param_wdata <= FLAG_MAX);
      ADDR_UPPER: rng_ok = (param_wdata <= LIMIT_MAX);
      ADDR_LOWER: rng_ok = (param_wdata <= LIMIT_MAX);
      default: rng_ok = 1'b1;
    endcase
  end

  // Source, halt key and limit settings are locked while the drive runs,
  // so a source cannot change under a moving motor.
  assign wr_ok = param_req && param_we && rng_ok &&
                 !(is_cfg(param_addr) && drive_run);

  // Configuration registers with their documented defaults.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_src <= RUN_PANEL;
      halt_key_sel <= 1'b0;
      rem_ref_sel <= REF_KNOB;
      loc_ref_sel <= 1'b0;
      upper_pct <= UPPER_RESET;
      lower_pct <= LOWER_RESET;
      pulse_input_scale <= PULSE_SCALE_RESET;
    end else if (wr_ok) begin
      case (param_addr)
        ADDR_RUN_SRC: run_src <= param_wdata[1:0];
        ADDR_HALT_KEY: halt_key_sel <= param_wdata[0];
        ADDR_REM_REF: rem_ref_sel <= param_wdata[3:0];
        ADDR_LOC_REF: loc_ref_sel <= param_wdata[0];
        ADDR_UPPER: upper_pct <= param_wdata;
        ADDR_LOWER: lower_pct <= param_wdata;
        ADDR_PULSE_SCALE: pulse_input_scale <= param_wdata;
        default: run_src <= run_src;
      endcase
    end
  end

  // Presets; a panel entry wins over a port write to slot zero.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PRESETS; gi++) begin : g_preset
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          preset_ref[gi] <= 16'h0000;
        end else if (gi == 0 && panel_entry_valid) begin
          preset_ref[gi] <= panel_entry_value;
        end else if (wr_ok && is_preset(param_addr) &&
                     preset_idx == 4'(gi)) begin
          preset_ref[gi] <= param_wdata;
        end
      end
    end
  endgenerate

  // Answer one cycle after the request; unmapped reads give zero.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      param_ack <= 1'b0;
      param_err <= 1'b0;
      param_rdata <= 16'h0000;
    end else begin
      param_ack <= param_req;
      param_err <= param_req && param_we && !wr_ok;
      param_rdata <= 16'h0000;
      if (param_req && !param_we) begin
        if (is_preset(param_addr)) begin
          param_rdata <= preset_ref[preset_idx];
        end else begin
          case (param_addr)
            ADDR_RUN_SRC: param_rdata <= {14'h0000, run_src};
            ADDR_HALT_KEY: param_rdata <= {15'h0000, halt_key_sel};
            ADDR_REM_REF: param_rdata <= {12'h000, rem_ref_sel};
            ADDR_LOC_REF: param_rdata <= {15'h0000, loc_ref_sel};
            ADDR_UPPER: param_rdata <= upper_pct;
            ADDR_LOWER: param_rdata <= lower_pct;
            ADDR_PULSE_SCALE: param_rdata <= pulse_input_scale;
            default: param_err <= 1'b1;
          endcase
        end
      end
    end
  end

  // ==========================================
  // Local and remote mode
  // ==========================================
  rsf_mode_t mode; // Current operating mode.

  // The mode key is ignored while running, as switching under a
  // running command would hand the motor to another source.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= RSF_MODE_REMOTE;
    end else if (mode_edge && !drive_run) begin
      case (mode)
        RSF_MODE_REMOTE: mode <= RSF_MODE_LOCAL;
        RSF_MODE_LOCAL: mode <= RSF_MODE_REMOTE;
        default: mode <= RSF_MODE_REMOTE;
      endcase
    end
  end

  // ==========================================
  // Run command selection
  // ==========================================
  logic src_cmd; // Level run command of a non-panel source.
  logic halted; // Stop key latched against a held source command.
  logic next_run; // Run state for the next cycle.
  logic next_halted; // Halt latch for the next cycle.

  // Level sources for remote run selections.
  always_comb begin
    case (run_src)
      RUN_TERM: src_cmd = term_run_s;
      RUN_MODBUS: src_cmd = modbus_run;
      RUN_FIELDBUS: src_cmd = fieldbus_run;
      default: src_cmd = 1'b0;
    endcase
  end

  // A stop from the panel against a level source holds until that
  // source drops its command, so the motor does not restart at once.
  always_comb begin
    next_run = drive_run;
    next_halted = halted;
    if (mode == RSF_MODE_LOCAL) begin
      next_halted = 1'b0;
      if (stop_edge) begin
        next_run = 1'b0;
      end else if (run_edge) begin
        next_run = 1'b1;
      end
    end else if (run_src == RUN_PANEL) begin
      next_halted = 1'b0;
      if (stop_edge) begin
        next_run = 1'b0;
      end else if (run_edge) begin
        next_run = 1'b1;
      end
    end else begin
      if (!src_cmd) begin
        next_halted = 1'b0;
      end else if (stop_edge && !halt_key_sel) begin
        next_halted = 1'b1;
      end
      next_run = src_cmd && !next_halted;
    end
  end

  // Run flag and halt latch.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_run <= 1'b0;
      halted <= 1'b0;
      local_mode <= 1'b0;
    end else begin
      drive_run <= next_run;
      halted <= next_halted;
      local_mode <= (mode == RSF_MODE_LOCAL);
    end
  end

  // ==========================================
  // Frequency reference selection
  // ==========================================
  logic [15:0] knob_ref; // Panel knob scaled to reference units.
  logic [15:0] pulse_ref; // Pulse train scaled to reference units.
  logic [31:0] pulse_prod; // Wide pulse quotient.
  logic [15:0] remote_ref; // Remote source reference.
  logic [15:0] step_ref; // After multi-step selection.
  logic [15:0] active_ref; // Mode-selected reference.
  logic [15:0] up_ref; // Upper limit in reference units.
  logic [15:0] lo_ref; // Lower limit in reference units.
  logic [15:0] next_ref; // Clamped reference.

  assign knob_ref = scale_adc(panel_reference_knob, ADC_ZERO,
                              ADC_SPAN_FULL);

  // A zero scale would divide by zero, so it gives no reference.
  always_comb begin
    pulse_prod = 32'h0000_0000;
    if (pulse_input_scale != 16'h0000) begin
      pulse_prod = (32'(pulse_in_panel_reference_knob) * 32'(FULL_REF)) /
                   32'(pulse_input_scale);
    end
    pulse_ref = (pulse_prod > 32'(REF_SAT)) ? REF_SAT : pulse_prod[15:0];
  end

  // Remote source multiplexer.
  always_comb begin
    case (rem_ref_sel)
      REF_KNOB: remote_ref = knob_ref;
      REF_PRESET: remote_ref = preset_ref[0];
      REF_VOLT: remote_ref = scale_adc(volt_in_code, ADC_ZERO,
                                       ADC_SPAN_FULL);
      REF_CUR_4: remote_ref = scale_adc(current_in_code, ADC_4MA,
                                        ADC_SPAN_4MA);
      REF_CUR_0: remote_ref = scale_adc(current_in_code, ADC_ZERO,
                                        ADC_SPAN_FULL);
      REF_PULSE: remote_ref = pulse_ref;
      REF_MODBUS: remote_ref = modbus_reference;
      REF_AUX_V: remote_ref = scale_adc(aux_volt_code, ADC_ZERO,
                                        ADC_SPAN_FULL);
      REF_AUX_I: remote_ref = scale_adc(aux_current_code, ADC_4MA,
                                        ADC_SPAN_4MA);
      REF_FIELDBUS: remote_ref = fieldbus_reference;
      default: remote_ref = 16'h0000;
    endcase
  end

  // Step zero is the remote source; other steps read presets.
  assign step_ref = (step_s == 4'h0) ? remote_ref
                                     : preset_ref[step_s];

  // Local mode uses the knob or the key-entered preset zero.
  assign active_ref = (mode == RSF_MODE_LOCAL) ?
                      (loc_ref_sel ? preset_ref[0] : knob_ref)
                      : step_ref;

  assign up_ref = 16'(upper_pct * PCT_UNIT);
  assign lo_ref = 16'(lower_pct * PCT_UNIT);

  // Limits act on every source; lower wins if limits cross.
  always_comb begin
    next_ref = active_ref;
    if (next_ref > up_ref) begin
      next_ref = up_ref;
    end
    if (next_ref < lo_ref) begin
      next_ref = lo_ref;
    end
    if (next_ref < minimum_output_frequency) begin
      next_ref = 16'h0000;
    end
  end

  // Registered reference output.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      panel_reference_knob_ref_out <= 16'h0000;
    end else begin
      panel_reference_knob_ref_out <= next_ref;
    end
  end

  // ==========================================
  // Checks
  // ==========================================
  chk_cfg_locked: assert property (@(posedge core_clk) disable iff (!rst_n)
    (param_req && param_we && param_addr == ADDR_UPPER && drive_run)
    |=> (param_err && upper_pct == $past(upper_pct)))
    else $error("Limit changed while running.");

  chk_run_src_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    (param_req && param_we && param_addr == ADDR_RUN_SRC &&
     param_wdata > RUN_SRC_MAX) |=> (param_ack && param_err))
    else $error("Out-of-range run source accepted.");

  chk_local_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == RSF_MODE_LOCAL && stop_edge) |=> !drive_run)
    else $error("Local stop key ignored.");

  chk_remote_halt: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == RSF_MODE_REMOTE && run_src == RUN_MODBUS && modbus_run &&
     !halted && !stop_edge) |=> drive_run)
    else $error("MODBUS run level not followed.");

  chk_upper_clamp: assert property (@(posedge core_clk) disable iff (!rst_n)
    (lo_ref <= up_ref) |=> (panel_reference_knob_ref_out <= $past(up_ref)))
    else $error("Reference above upper limit.");

  chk_min_output: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 (panel_reference_knob_ref_out == 16'h0000 ||
         panel_reference_knob_ref_out >= $past(minimum_output_frequency)))
    else $error("Reference below minimum output.");

  chk_preset_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    panel_entry_valid |=> (preset_ref[0] == $past(panel_entry_value)))
    else $error("Panel entry not stored.");

  chk_mode_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    drive_run |=> (mode == $past(mode)))
    else $error("Mode changed while running.");

  chk_step_preset: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mode == RSF_MODE_REMOTE && step_s == 4'h2 && lo_ref == 16'h0000 &&
     preset_ref[2] <= up_ref && preset_ref[2] >= minimum_output_frequency)
    |=> (panel_reference_knob_ref_out == $past(preset_ref[2])))
    else $error("Step two preset not used.");
endmodule : rsf_select
`default_nettype wire

// File: dv/rsf_host.sv
// Purpose: Host controller model driving the parameter port.
// Assumes: One request at a time, strobe high for one cycle.
// Notes: Released address and data show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module rsf_host (
  input wire logic core_clk,
  input wire logic param_ack,
  input wire logic param_err,
  input wire logic [15:0] param_rdata,
  output logic param_req,
  output logic param_we,
  output logic [15:0] param_addr,
  output logic [15:0] param_wdata
);
  // ==========================================
  // Idle state
  // ==========================================
  initial begin
    param_req = 1'b0;
    param_we = 1'b0;
    param_addr = 16'h0000;
    param_wdata = 16'h0000;
  end
  // The answer lands on the taking edge itself; it is read once it has settled.
  task automatic xfer(input logic we, input logic [15:0] a, input logic [15:0] d,
                      output logic err, output logic ack, output logic [15:0] rd);
    @(posedge core_clk);
    param_req <= 1'b1;
    param_we <= we;
    param_addr <= a;
    param_wdata <= d;
    @(posedge core_clk);
    param_req <= 1'b0;
    param_addr <= ~a;
    param_wdata <= ~d;
    #1;
    err = param_err;
    ack = param_ack;
    rd = param_rdata;
  endtask : xfer
endmodule : rsf_host
`default_nettype wire

// File: dv/run_source_panel_reference_knob_ref_select_tb_top.sv
// Purpose: Self-checking bench for run source and reference selection.
// Assumes: The host model owns the parameter port.
// Notes: Converter codes are driven at zero, the 4 mA point or full scale only.
`timescale 1ns/1ps
`default_nettype none
module run_source_panel_reference_knob_ref_select_tb_top;
  import rsf_pkg::*;
  // ==========================================
  // Signals
  // ==========================================
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic param_req, param_we, param_ack, param_err, drive_run, local_mode;
  logic [15:0] param_addr, param_wdata, param_rdata, panel_reference_knob_ref_out;
  logic [2:0] keys = 3'h0;
  logic terminal_run = 1'b0, modbus_run = 1'b0, fieldbus_run = 1'b0, pe_v = 1'b0;
  logic [3:0] step_select = 4'h0;
  logic [11:0] an = 12'h0000, cur = 12'h0000;
  logic [15:0] pls = 16'h0000, mbr = 16'h0000, fbr = 16'h0000, minf = 16'h0000;
  logic [15:0] pev = 16'h0000, pr;
  int failures = 0, total_checks = 0, up = 100, lo = 0, cycles = 0, f;
  rsf_select u_dut (.core_clk, .rst_n, .param_req, .param_we, .param_addr, .param_wdata,
    .param_ack, .param_err, .param_rdata, .panel_run_key(keys[0]), .panel_stop_key(keys[1]),
    .panel_mode_key(keys[2]), .terminal_run, .step_select, .modbus_run, .fieldbus_run,
    .panel_entry_valid(pe_v), .panel_entry_value(pev), .panel_reference_knob(an),
    .volt_in_code(an), .current_in_code(cur), .aux_volt_code(an), .aux_current_code(cur),
    .pulse_in_panel_reference_knob(pls), .modbus_reference(mbr), .fieldbus_reference(fbr),
    .minimum_output_frequency(minf), .drive_run, .local_mode, .panel_reference_knob_ref_out);
  rsf_host u_host (.core_clk, .param_ack, .param_err, .param_rdata, .param_req, .param_we,
    .param_addr, .param_wdata);
  always #5 core_clk = ~core_clk;
  // A hang is cut short well beyond the expected run length.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end
  // ==========================================
  // Tasks
  // ==========================================
  task automatic end_of_test();
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic ck(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : ck
  // A read passes its expected data in d.
  task automatic acc(input logic we, input logic [15:0] a, input logic [15:0] d, input logic ee);
    logic e;
    logic k;
    logic [15:0] r;
    u_host.xfer(we, a, d, e, k, r);
    ck("param_ack", 16'h0001, {15'h0000, k});
    ck("param_err", {15'h0000, ee}, {15'h0000, e});
    if (!we) ck("param_rdata", d, r);
  endtask : acc
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle
  // Keys are held long enough to pass the pin synchroniser.
  task automatic press(input int k);
    @(posedge core_clk) keys[k] <= 1'b1;
    repeat (4) @(posedge core_clk);
    keys[k] <= 1'b0;
  endtask : press
  task automatic ck_run(input logic e);
    ck("drive_run", {15'h0000, e}, {15'h0000, drive_run});
  endtask : ck_run
  // Upper first, then lower, then the minimum output cut.
  function automatic logic [15:0] clampf(input int raw);
    int v;
    v = raw;
    if (v > up * 100) v = up * 100;
    if (v < lo * 100) v = lo * 100;
    if (v < int'(minf)) v = 0;
    return 16'(v);
  endfunction : clampf
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    void'($urandom(63167));
    repeat (20) @(posedge core_clk);
    @(posedge core_clk) rst_n <= 1'b1;
    settle(1);
    ck("local_mode", 16'h0000, {15'h0000, local_mode});
    acc(0, ADDR_RUN_SRC, 16'h0000, 0);
    acc(0, ADDR_HALT_KEY, 16'h0000, 0);
    acc(0, ADDR_REM_REF, 16'h0000, 0);
    acc(0, ADDR_LOC_REF, 16'h0000, 0);
    acc(0, ADDR_UPPER, UPPER_RESET, 0);
    acc(0, ADDR_LOWER, LOWER_RESET, 0);
    acc(0, ADDR_PULSE_SCALE, PULSE_SCALE_RESET, 0);
    acc(0, 16'h0200, 16'h0000, 1);
    acc(1, ADDR_RUN_SRC, 16'h0004, 1);
    acc(1, ADDR_REM_REF, 16'h000A, 1);
    acc(1, ADDR_LOC_REF, 16'h0002, 1);
    acc(1, ADDR_UPPER, 16'h006F, 1);
    acc(1, ADDR_UPPER, 16'h006E, 0);
    acc(1, ADDR_UPPER, UPPER_RESET, 0);
    pr = 16'($urandom % 10000);
    acc(1, ADDR_PRESET_BASE, pr, 0);
    // Every remote source, first with default limits, then with narrowed ones.
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        up = 50;
        lo = 20;
        acc(1, ADDR_UPPER, 16'h0032, 0);
        acc(1, ADDR_LOWER, 16'h0014, 0);
      end
      for (int s = 0; s < 10; s++) begin
        f = $urandom % 2;
        acc(1, ADDR_REM_REF, 16'(s), 0);
        @(posedge core_clk) begin
          an <= f ? 12'h0FFF : 12'h0000;
          cur <= f ? 12'h0FFF : (s == 4 ? 12'h0000 : 12'h0333);
          pls <= f ? PULSE_SCALE_RESET : 16'h0000;
          mbr <= 16'($urandom % 12000);
          fbr <= 16'($urandom % 12000);
        end
        settle(2);
        f = (s == 1) ? pr : (s == 6) ? mbr : (s == 9) ? fbr : (f ? FULL_REF : 0);
        ck("panel_reference_knob_ref_out", clampf(f), panel_reference_knob_ref_out);
      end
    end
    lo = 0;
    acc(1, ADDR_LOWER, 16'h0000, 0);
    acc(1, ADDR_REM_REF, 16'h0006, 0);
    @(posedge core_clk) minf <= 16'h0BB8;
    @(posedge core_clk) mbr <= 16'h07D0;
    settle(2);
    ck("panel_reference_knob_ref_out", 16'h0000, panel_reference_knob_ref_out);
    @(posedge core_clk) mbr <= 16'h0FA0;
    settle(2);
    ck("panel_reference_knob_ref_out", clampf(4000), panel_reference_knob_ref_out);
    @(posedge core_clk) minf <= 16'h0000;
    pr = 16'($urandom % 5000);
    acc(1, 16'h0132, pr, 0);
    @(posedge core_clk) step_select <= 4'h2;
    settle(5);
    ck("panel_reference_knob_ref_out", clampf(pr), panel_reference_knob_ref_out);
    @(posedge core_clk) step_select <= 4'h0;
    // Each run source starts the drive, is locked while running and is stopped by the key.
    for (int s = 0; s < 4; s++) begin
      acc(1, ADDR_RUN_SRC, 16'(s), 0);
      @(posedge core_clk) begin
        terminal_run <= (s == 1);
        modbus_run <= (s == 2);
        fieldbus_run <= (s == 3);
      end
      if (s == 0) press(0);
      settle(5);
      ck_run(1'b1);
      acc(1, ADDR_RUN_SRC, 16'h0000, 1);
      acc(1, ADDR_UPPER, 16'h0010, 1);
      press(1);
      settle(3);
      ck_run(1'b0);
      @(posedge core_clk) {terminal_run, modbus_run, fieldbus_run} <= 3'h0;
    end
    acc(1, ADDR_RUN_SRC, 16'h0002, 0);
    acc(1, ADDR_HALT_KEY, 16'h0001, 0);
    @(posedge core_clk) modbus_run <= 1'b1;
    press(1);
    settle(3);
    ck_run(1'b1);
    @(posedge core_clk) modbus_run <= 1'b0;
    settle(3);
    ck_run(1'b0);
    press(2);
    settle(3);
    ck("local_mode", 16'h0001, {15'h0000, local_mode});
    @(posedge core_clk) modbus_run <= 1'b1;
    settle(5);
    ck_run(1'b0);
    @(posedge core_clk) modbus_run <= 1'b0;
    acc(1, ADDR_LOC_REF, 16'h0001, 0);
    pr = 16'($urandom % 10000);
    @(posedge core_clk) begin
      pev <= pr;
      pe_v <= 1'b1;
    end
    @(posedge core_clk) pe_v <= 1'b0;
    settle(3);
    ck("panel_reference_knob_ref_out", clampf(pr), panel_reference_knob_ref_out);
    acc(0, ADDR_PRESET_BASE, pr, 0);
    press(0);
    settle(3);
    ck_run(1'b1);
    press(2);
    settle(3);
    ck("local_mode", 16'h0001, {15'h0000, local_mode});
    press(1);
    settle(3);
    ck_run(1'b0);
    end_of_test();
  end
endmodule : run_source_panel_reference_knob_ref_select_tb_top
`default_nettype wire
